// *** logic/bwc_bridge_regs.sv ***
// bridge window upper halves, capability pointer, interrupt and bridge control
`timescale 1ns/1ps
`include "bwc_consts.svh"

// ----------------------------------------------------------------------------
// What this block does
// ----------------------------------------------------------------------------
// What this block does
// RULE1 - rw 32-bit prefetch limit upper address bits 63..32, resets zero
// RULE2 - prefetch limit low twenty address bits are taken as all ones
// RULE3 - rw io base upper 16 bits at 30h bits 15..0, reset zero
// RULE4 - rw io limit upper 16 bits at 30h bits 31..16, reset zero
// RULE5 - capability pointer byte reads 40h, read only
// RULE6 - hot-plug events raise inta; interrupt pin byte read only, resets 00h; code raises inta only on a downstream port with a nonzero pin
// RULE7 - downstream interrupt pin default may be loaded by smbus, i2c or eeprom
// RULE8 - bit 16 clear ignores poisoned tlps, set detects and reports them
// RULE9 - bit 17 forwards secondary error messages to primary, clear blocks them
// RULE10 - bit 18 sends isa top-768 io window addresses below 64KB upstream
// RULE11 - bit 19 forwards legacy video memory A0000h..BFFFFh, else ignored
// RULE12 - video enabled forwards io below 64KB at 3B0h..3BBh, 3C0h..3DFh
// RULE13 - bit 20 selects 16-bit instead of 10-bit video io decode
// RULE14 - bit 22 on downstream port hot resets it and asserts its reset out
// RULE15 - bit 22 on upstream port asserts reset at every downstream port
// RULE16 - bits 21 and 23..27 read zero, writes ignored
// RULE17 - window hit means base <= address <= limit at full width
// RULE18 - reserved bridge control bits 31..28 read zero, writes preserve
module bwc_bridge_regs
    import bwc_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b0,
    parameter int NUM_DOWN    = 1
) (
    input  wire logic                core_clk,
    input  wire logic                srst,
    // configuration requests
    input  wire logic                cfg_wr,
    input  wire logic                cfg_rd,
    input  wire logic [7:0]          cfg_addr,
    input  wire logic [3:0]          cfg_be,
    input  wire logic [31:0]         cfg_wdata,
    output logic                     cfg_rvalid,
    output logic [31:0]              cfg_rdata,
    // default load from smbus, i2c or eeprom
    input  wire logic                ld_int_pin_wr,
    input  wire logic [7:0]          ld_int_pin,
    // lower window halves and prefetch base upper dword from the neighbouring registers
    input  wire logic [31:0]         pf_base_upper,
    input  wire logic [11:0]         pf_base_low,
    input  wire logic [11:0]         pf_limit_low,
    input  wire logic [3:0]          io_base_low,
    input  wire logic [3:0]          io_limit_low,
    // address decode
    input  wire logic                dec_valid,
    input  wire logic                dec_is_io,
    input  wire bwc_addr_t           dec_addr,
    output logic                     dec_done,
    output logic                     fwd_down,
    output logic                     fwd_up,
    // secondary side errors
    input  wire logic                sec_poison,
    input  wire logic                sec_err_valid,
    input  wire bwc_err_e            sec_err_type,
    output logic                     poison_seen,
    output logic                     pri_err_valid,
    output bwc_err_e                 pri_err_type,
    // hot-plug interrupt and resets
    input  wire logic                hp_event,
    output logic                     inta_assert,
    output logic                     link_hot_rst,
    output logic [NUM_DOWN-1:0]      port_rst_n
);
    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    logic [31:0] pf_limit_upper;
    logic [15:0] io_base_upper;
    logic [15:0] io_limit_upper;
    logic [7:0]  int_line;
    logic [7:0]  int_pin;
    // only bits 16..23 of the dword are stored
    logic [7:0]  bridge_ctl;
    logic        hp_pending;

    logic wr_pf;
    logic wr_io;
    logic wr_ib;

    always_comb begin
        wr_pf = cfg_wr && (cfg_addr == `BWC_OFF_PF_LIMIT_UP);
        wr_io = cfg_wr && (cfg_addr == `BWC_OFF_IO_UPPER);
        wr_ib = cfg_wr && (cfg_addr == `BWC_OFF_INTR_BRIDGE);
    end

    // ------------------------------------------------------------------------
    // prefetch limit upper dword
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pf_byte
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    pf_limit_upper[gi*8 +: 8] <= 8'(`BWC_RST_PF_LIMIT_UP >> (gi*8)); // RULE1
                end else if (wr_pf && cfg_be[gi]) begin
                    pf_limit_upper[gi*8 +: 8] <= cfg_wdata[gi*8 +: 8]; // RULE1
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // io base and limit upper halves
    // ------------------------------------------------------------------------
    generate
        for (gi = 0; gi < 2; gi++) begin : g_io_byte
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    io_base_upper[gi*8 +: 8]  <= 8'(`BWC_RST_IO_UPPER >> (gi*8)); // RULE3
                    io_limit_upper[gi*8 +: 8] <= 8'(`BWC_RST_IO_UPPER >> (gi*8)); // RULE4
                end else if (wr_io) begin
                    if (cfg_be[gi]) begin
                        io_base_upper[gi*8 +: 8] <= cfg_wdata[gi*8 +: 8]; // RULE3
                    end
                    if (cfg_be[gi+2]) begin
                        io_limit_upper[gi*8 +: 8] <= cfg_wdata[16 + gi*8 +: 8]; // RULE4
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // interrupt line and pin
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            int_line <= `BWC_RST_INT_LINE;
        end else if (wr_ib && cfg_be[0]) begin
            int_line <= cfg_wdata[7:0];
        end
    end

    // host writes never reach the pin byte; only the sideband loader does
    always_ff @(posedge core_clk) begin
        if (srst) begin
            int_pin <= `BWC_RST_INT_PIN; // RULE6
        end else if (ld_int_pin_wr && !IS_UPSTREAM) begin
            int_pin <= ld_int_pin; // RULE7
        end
    end

    // ------------------------------------------------------------------------
    // bridge control: only writable bits are kept, the rest stay zero
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bridge_ctl <= `BWC_RST_BRIDGE_CTL;
        end else if (wr_ib && cfg_be[2]) begin
            bridge_ctl <= cfg_wdata[23:16] & `BWC_BC_WR_MASK; // RULE16
        end
    end

    // ------------------------------------------------------------------------
    // configuration read path
    // ------------------------------------------------------------------------
    // rdata holds between reads for a slow host
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (cfg_addr)
            `BWC_OFF_PF_LIMIT_UP: begin
                next_rdata = pf_limit_upper;
            end
            `BWC_OFF_IO_UPPER: begin
                next_rdata = {io_limit_upper, io_base_upper};
            end
            `BWC_OFF_CAP_PTR: begin
                next_rdata = {24'h00_0000, `BWC_CAP_PTR_VAL}; // RULE5
            end
            `BWC_OFF_INTR_BRIDGE: begin
                // upper byte is all legacy or reserved bits and reads zero
                next_rdata = {8'h00, bridge_ctl, int_pin, int_line}; // RULE18
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_rvalid <= 1'b0;
            cfg_rdata  <= 32'h0000_0000;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // hot-plug interrupt as inta virtual wire
    // ------------------------------------------------------------------------
    // level follows the event source; no pin means no interrupt message
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hp_pending  <= 1'b0;
            inta_assert <= 1'b0;
        end else begin
            hp_pending  <= hp_event && !IS_UPSTREAM;
            inta_assert <= hp_pending && (int_pin != 8'h00); // RULE6
        end
    end

    // ------------------------------------------------------------------------
    // secondary bus reset
    // ------------------------------------------------------------------------
    // a level: reset stays on until software clears bit 22
    logic sec_rst;

    always_comb begin
        sec_rst = bridge_ctl[`BWC_BC_SEC_RST];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            link_hot_rst <= 1'b0;
            port_rst_n   <= {NUM_DOWN{1'b1}};
        end else begin
            link_hot_rst <= sec_rst; // RULE14
            // an upstream port drives every downstream reset at once
            port_rst_n   <= {NUM_DOWN{~sec_rst}}; // RULE15
        end
    end

    // ------------------------------------------------------------------------
    // assembled windows and decode
    // ------------------------------------------------------------------------
    bwc_addr_t   pf_base;
    bwc_addr_t   pf_limit;
    logic [31:0] io_base;
    logic [31:0] io_limit;

    always_comb begin
        pf_base  = {pf_base_upper, pf_base_low, `BWC_MEM_LOW_ZERO};
        pf_limit = {pf_limit_upper, pf_limit_low, `BWC_MEM_LOW_ONES}; // RULE2
        io_base  = {io_base_upper, io_base_low, `BWC_IO_LOW_ZERO}; // RULE3
        io_limit = {io_limit_upper, io_limit_low, `BWC_IO_LOW_ONES}; // RULE4
    end

    bwc_window_dec u_dec (
        .core_clk (core_clk),
        .srst     (srst),
        .dec_valid(dec_valid),
        .dec_is_io(dec_is_io),
        .dec_addr (dec_addr),
        .pf_base  (pf_base),
        .pf_limit (pf_limit),
        .io_base  (io_base),
        .io_limit (io_limit),
        .isa_en   (bridge_ctl[`BWC_BC_ISA_EN]),
        .vga_en   (bridge_ctl[`BWC_BC_VGA_EN]),
        .vga16    (bridge_ctl[`BWC_BC_VGA16]),
        .dec_done (dec_done),
        .fwd_down (fwd_down),
        .fwd_up   (fwd_up)
    );

    bwc_err_gate u_err (
        .core_clk     (core_clk),
        .srst         (srst),
        .perr_resp    (bridge_ctl[`BWC_BC_PERR_RESP]),
        .serr_fwd_en  (bridge_ctl[`BWC_BC_SERR_FWD]),
        .sec_poison   (sec_poison),
        .sec_err_valid(sec_err_valid),
        .sec_err_type (sec_err_type),
        .poison_seen  (poison_seen),
        .pri_err_valid(pri_err_valid),
        .pri_err_type (pri_err_type)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_cap_ptr_value: assert property ( // RULE5
        (cfg_rd && cfg_addr == `BWC_OFF_CAP_PTR)
            |=> cfg_rvalid && cfg_rdata == {24'h00_0000, `BWC_CAP_PTR_VAL})
        else $error("capability pointer read wrong");
    // writes show one cycle on
    a_pf_limit_rw: assert property ( // RULE1
        (wr_pf && cfg_be == 4'hF) |=> pf_limit_upper == $past(cfg_wdata))
        else $error("prefetch limit write lost");
    a_int_line_rw: assert property (
        (wr_ib && cfg_be[0]) |=> int_line == $past(cfg_wdata[7:0]))
        else $error("int line write lost");
    a_bc_enables: assert property ( // RULE8
        (wr_ib && cfg_be[2]) |=> bridge_ctl[4:0] == $past(cfg_wdata[20:16]))
        else $error("bridge enables write lost");
    a_sec_rst_clear: assert property ( // RULE14
        (wr_ib && cfg_be[2] && !cfg_wdata[22]) |=> ##1 !link_hot_rst)
        else $error("hot reset without bit 22");
    a_rvalid_pulse: assert property (
        !cfg_rd |=> !cfg_rvalid)
        else $error("read valid without read");
    a_rdata_hold: assert property (
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (
        (cfg_rd && !(cfg_addr inside {`BWC_OFF_PF_LIMIT_UP, `BWC_OFF_IO_UPPER,
            `BWC_OFF_CAP_PTR, `BWC_OFF_INTR_BRIDGE})) |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped read nonzero");
    a_io_base_rw: assert property ( // RULE3
        (wr_io && cfg_be[1:0] == 2'h3) |=> io_base_upper == $past(cfg_wdata[15:0]))
        else $error("io base upper did not store write");
    a_io_limit_rw: assert property ( // RULE4
        (wr_io && cfg_be[3:2] == 2'h3) |=> io_limit_upper == $past(cfg_wdata[31:16]))
        else $error("io limit upper did not store write");
    a_pf_limit_ones: assert property ( // RULE2
        pf_limit[19:0] == `BWC_MEM_LOW_ONES && pf_limit[63:32] == pf_limit_upper)
        else $error("prefetch limit assembly wrong");
    a_int_pin_ro: assert property ( // RULE6
        (wr_ib && !ld_int_pin_wr) |=> $stable(int_pin))
        else $error("host write changed interrupt pin");
    a_int_pin_load: assert property ( // RULE7
        (ld_int_pin_wr && !IS_UPSTREAM) |=> int_pin == $past(ld_int_pin))
        else $error("interrupt pin default not loaded");
    a_bc_zero_bits: assert property ( // RULE16
        (cfg_rd && cfg_addr == `BWC_OFF_INTR_BRIDGE)
            |=> cfg_rdata[31:23] == 9'h000 && cfg_rdata[21] == 1'b0)
        else $error("legacy or reserved bridge bits read nonzero");
    a_sec_rst_assert: assert property ( // RULE14
        (wr_ib && cfg_be[2] && cfg_wdata[22]) |=> ##1 (link_hot_rst && port_rst_n == '0))
        else $error("secondary bus reset did not assert port reset");
    a_sec_rst_release: assert property ( // RULE15
        !sec_rst |=> port_rst_n == {NUM_DOWN{1'b1}})
        else $error("port reset held while bit clear");
    a_hp_inta: assert property ( // RULE6
        (hp_event && !IS_UPSTREAM && int_pin != 8'h00) ##1 (int_pin != 8'h00) |=> inta_assert)
        else $error("hot-plug event raised no interrupt");
endmodule : bwc_bridge_regs

// *** pkg/bwc_consts.svh ***
// offsets, field positions and reset values of the bridge window and control registers
`ifndef BWC_CONSTS_SVH
`define BWC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses of aligned dwords)
// ----------------------------------------------------------------------------
`define BWC_OFF_PF_LIMIT_UP   8'h2C
`define BWC_OFF_IO_UPPER      8'h30
`define BWC_OFF_CAP_PTR       8'h34
`define BWC_OFF_INTR_BRIDGE   8'h3C

// ----------------------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------------------
`define BWC_RST_PF_LIMIT_UP   32'h0000_0000
`define BWC_RST_IO_UPPER      16'h0000
`define BWC_RST_INT_LINE      8'h00
`define BWC_RST_INT_PIN       8'h00
`define BWC_RST_BRIDGE_CTL    8'h00
`define BWC_CAP_PTR_VAL       8'h40

// ----------------------------------------------------------------------------
// bridge control bits, as positions inside byte 2 of the dword at 3Ch
// ----------------------------------------------------------------------------
`define BWC_BC_PERR_RESP      0
`define BWC_BC_SERR_FWD       1
`define BWC_BC_ISA_EN         2
`define BWC_BC_VGA_EN         3
`define BWC_BC_VGA16          4
`define BWC_BC_SEC_RST        6
`define BWC_BC_WR_MASK        8'h5F

// ----------------------------------------------------------------------------
// window assembly and legacy ranges
// ----------------------------------------------------------------------------
`define BWC_MEM_LOW_ONES      20'hFFFFF
`define BWC_MEM_LOW_ZERO      20'h00000
`define BWC_IO_LOW_ONES       12'hFFF
`define BWC_IO_LOW_ZERO       12'h000
`define BWC_VGA_MEM_LO        64'h0000_0000_000A_0000
`define BWC_VGA_MEM_HI        64'h0000_0000_000B_FFFF
`define BWC_VGA_IO_A_LO       10'h3B0
`define BWC_VGA_IO_A_HI       10'h3BB
`define BWC_VGA_IO_B_LO       10'h3C0
`define BWC_VGA_IO_B_HI       10'h3DF
`define BWC_ISA_TOP_LO        10'h100

`endif

// *** pkg/bwc_pkg.sv ***
// types shared by the bridge window and control blocks
package bwc_pkg;
    typedef enum logic [1:0] {
        BWC_ERR_COR      = 2'b00,
        BWC_ERR_NONFATAL = 2'b01,
        BWC_ERR_FATAL    = 2'b10,
        BWC_ERR_NONE     = 2'b11
    } bwc_err_e;
    typedef logic [63:0] bwc_addr_t;
endpackage : bwc_pkg

// *** logic/bwc_err_gate.sv ***
// poisoned tlp and secondary error message gating
`timescale 1ns/1ps
module bwc_err_gate
    import bwc_pkg::*;
(
    input  wire logic     core_clk,
    input  wire logic     srst,
    input  wire logic     perr_resp,
    input  wire logic     serr_fwd_en,
    input  wire logic     sec_poison,
    input  wire logic     sec_err_valid,
    input  wire bwc_err_e sec_err_type,
    output logic          poison_seen,
    output logic          pri_err_valid,
    output bwc_err_e      pri_err_type
);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            poison_seen <= 1'b0;
        end else begin
            poison_seen <= sec_poison & perr_resp; // RULE8
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pri_err_valid <= 1'b0;
            pri_err_type  <= BWC_ERR_NONE;
        end else begin
            pri_err_valid <= sec_err_valid & serr_fwd_en & (sec_err_type != BWC_ERR_NONE); // RULE9
            pri_err_type  <= sec_err_type;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_poison_gate: assert property ( // RULE8
        poison_seen == $past(sec_poison && perr_resp))
        else $error("poison report does not follow the enable");
    a_err_fwd: assert property ( // RULE9
        (sec_err_valid && !serr_fwd_en) |=> !pri_err_valid)
        else $error("error message forwarded while blocked");
    a_err_type: assert property ( // RULE9
        (sec_err_valid && serr_fwd_en && sec_err_type != BWC_ERR_NONE)
            |=> pri_err_valid && pri_err_type == $past(sec_err_type))
        else $error("enabled error message not forwarded");
endmodule : bwc_err_gate

// *** logic/bwc_window_dec.sv ***
// forwarding window, isa and legacy video decode
`timescale 1ns/1ps
`include "bwc_consts.svh"
module bwc_window_dec
    import bwc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        dec_valid,
    input  wire logic        dec_is_io,
    input  wire bwc_addr_t   dec_addr,
    input  wire bwc_addr_t   pf_base,
    input  wire bwc_addr_t   pf_limit,
    input  wire logic [31:0] io_base,
    input  wire logic [31:0] io_limit,
    input  wire logic        isa_en,
    input  wire logic        vga_en,
    input  wire logic        vga16,
    output logic             dec_done,
    output logic             fwd_down,
    output logic             fwd_up
);
    function automatic logic in_range(input bwc_addr_t a, input bwc_addr_t lo,
                                      input bwc_addr_t hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic io_win;
    logic pf_win;
    logic lo64k;
    logic isa_top;
    logic vga_io;
    logic vga_mem;
    logic [9:0] a10;

    always_comb begin
        a10     = dec_addr[9:0];
        io_win  = in_range(dec_addr, {32'h0, io_base}, {32'h0, io_limit}); // RULE17
        pf_win  = in_range(dec_addr, pf_base, pf_limit); // RULE17
        lo64k   = (dec_addr[63:16] == 48'h0);
        isa_top = lo64k && (a10 >= `BWC_ISA_TOP_LO); // RULE10
        // 10-bit decode aliases the video ports through every 1KB block below 64KB
        vga_io  = (dec_addr[63:16] == 48'h0) && (!vga16 || dec_addr[15:10] == 6'h00) // RULE13
                  && (((a10 >= `BWC_VGA_IO_A_LO) && (a10 <= `BWC_VGA_IO_A_HI))
                  || ((a10 >= `BWC_VGA_IO_B_LO) && (a10 <= `BWC_VGA_IO_B_HI))); // RULE12
        vga_mem = in_range(dec_addr, `BWC_VGA_MEM_LO, `BWC_VGA_MEM_HI); // RULE11
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dec_done <= 1'b0;
            fwd_down <= 1'b0;
            fwd_up   <= 1'b0;
        end else begin
            dec_done <= dec_valid;
            if (dec_valid) begin
                if (dec_is_io) begin
                    fwd_up   <= io_win && isa_en && isa_top; // RULE10
                    fwd_down <= (io_win && !(isa_en && isa_top)) || (vga_en && vga_io); // RULE12
                end else begin
                    fwd_up   <= 1'b0;
                    fwd_down <= pf_win || (vga_en && vga_mem); // RULE11
                end
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_vga_mem_off: assert property ( // RULE11
        (dec_valid && !dec_is_io && !vga_en && !pf_win) |=> !fwd_down)
        else $error("video memory forwarded while disabled");
    a_pf_window: assert property ( // RULE17
        (dec_valid && !dec_is_io) |=> (fwd_down == $past(pf_win || (vga_en && vga_mem))))
        else $error("prefetch window decision wrong");
    a_isa_upstream: assert property ( // RULE10
        (dec_valid && dec_is_io && io_win && isa_en && isa_top) |=> fwd_up)
        else $error("isa range not sent upstream");
endmodule : bwc_window_dec

// *** dv/bwc_host_model.sv ***
// host model issuing configuration requests to the register port
`timescale 1ns/1ps
module bwc_host_model (
    input  wire logic  core_clk,
    output logic       cfg_wr,
    output logic       cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    initial begin
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
    end
    // idle address, enable and data lines show the inverse so a stale value never passes for a new one; wr and rd idle low
    task automatic req(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        @(negedge core_clk);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, be, d};
        @(negedge core_clk);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {2'b00, ~a, ~be, ~d};
    endtask : req
endmodule : bwc_host_model

// *** dv/tb_top.sv ***
// self-checking bench for the bridge window and control registers
`timescale 1ns/1ps
module tb_top;
    import bwc_pkg::*;
    logic        core_clk = 0, srst = 1, ld_wr = 0, dv = 0, dio = 0, sp = 0, sv = 0, hp = 0;
    logic [7:0]  ld_pin = 0, ctl = 0, cfg_addr;
    logic [63:0] da = 0;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [3:0]  cfg_be, iob = 4'h1, iol = 4'h4;
    logic        cfg_wr, cfg_rd, cfg_rvalid, dd, fd, fu, ps, pv, inta, lhr;
    logic [0:0]  prn;
    bwc_err_e    et = BWC_ERR_NONE, pt;
    int          fail_count = 0, n_compared = 0;
    always #50 core_clk = ~core_clk;
    bwc_host_model host_u (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    // prefetch lower halves tied: 800h..900h granules
    bwc_bridge_regs #(.IS_UPSTREAM(1'b0), .NUM_DOWN(1)) dut_u (.core_clk(core_clk),
        .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
        .ld_int_pin_wr(ld_wr), .ld_int_pin(ld_pin), .pf_base_upper(32'h0),
        .pf_base_low(12'h800), .pf_limit_low(12'h900), .io_base_low(iob),
        .io_limit_low(iol), .dec_valid(dv), .dec_is_io(dio), .dec_addr(da), .dec_done(dd),
        .fwd_down(fd), .fwd_up(fu), .sec_poison(sp), .sec_err_valid(sv), .sec_err_type(et),
        .poison_seen(ps), .pri_err_valid(pv), .pri_err_type(pt), .hp_event(hp),
        .inta_assert(inta), .link_hot_rst(lhr), .port_rst_n(prn));
    // ------------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------------
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host_u.req(1'b0, a, 4'hF, 32'h0);
        chk({cfg_rvalid, cfg_rdata}, {1'b1, e});
    endtask : rd
    task automatic test_done;
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    function automatic logic [1:0] exp_fwd(input logic io, input logic [63:0] a,
                                           input logic [7:0] c);
        logic win, isa, vid;
        isa = a < 64'h10000 && a[9:0] >= 10'h100;
        vid = a[63:16] == 0 && (!c[4] || a[15:10] == 0)
              && (a[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]});
        win = a >= {48'h0, iob, 12'h000} && a <= {48'h0, iol, 12'hFFF};
        if (!io)
            return {(a >= 64'h8000_0000 && a <= 64'h1_900F_FFFF)
                    || (c[3] && a >= 64'hA_0000 && a <= 64'hB_FFFF), 1'b0};
        return {(win && !(c[2] && isa)) || (c[3] && vid), win && c[2] && isa};
    endfunction : exp_fwd
    task automatic step(input logic io, input logic [63:0] a);
        logic p, e, ev;
        p = 1'($urandom);
        e = 1'($urandom);
        @(negedge core_clk);
        {dv, dio, da, sp, sv} = {1'b1, io, a, p, e};
        et = bwc_err_e'(2'($urandom));
        ev = e && ctl[1] && et != BWC_ERR_NONE;
        @(negedge core_clk);
        {dv, sp, sv} = 3'b000;
        chk({dd, fd, fu}, {1'b1, exp_fwd(io, a, ctl)});
        chk(ps, p && ctl[0]);
        chk(pv, ev);
        if (ev) chk(pt, et);
    endtask : step
    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [9:0]  lo;
        void'($urandom(32'hB575));
        repeat (12) @(negedge core_clk);
        srst = 0;
        rd(8'h2C, 32'h0);
        rd(8'h30, 32'h0);
        rd(8'h34, 32'h40);
        rd(8'h3C, 32'h0);
        rd(8'h38, 32'h0);
        r = $urandom;
        host_u.req(1'b1, 8'h2C, 4'hF, r);
        host_u.req(1'b1, 8'h30, 4'hF, ~r);
        host_u.req(1'b1, 8'h34, 4'hF, r);
        rd(8'h2C, r);
        rd(8'h30, ~r);
        rd(8'h34, 32'h40);
        host_u.req(1'b1, 8'h3C, 4'hF, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h005F_00FF);
        @(negedge core_clk);
        chk({lhr, prn}, 2'b10);
        host_u.req(1'b1, 8'h3C, 4'h4, 32'hFF00_FFFF);
        repeat (3) @(negedge core_clk);
        chk({lhr, prn}, 2'b01);
        {ld_wr, ld_pin} = {1'b1, 8'h01};
        @(negedge core_clk);
        ld_wr = 0;
        rd(8'h3C, 32'h0000_01FF);
        hp = 1;
        repeat (3) @(negedge core_clk);
        chk(inta, 1'b1);
        hp = 0;
        repeat (3) @(negedge core_clk);
        chk(inta, 1'b0);
        host_u.req(1'b1, 8'h2C, 4'hF, 32'h1);
        host_u.req(1'b1, 8'h30, 4'hF, 32'h0);
        for (int k = 0; k < 8; k++) begin
            ctl = {3'b000, 3'(k), 2'($urandom)};
            {iob, iol} = {4'($urandom), 4'($urandom)};
            host_u.req(1'b1, 8'h3C, 4'h4, {8'hFF, ctl, 16'h0});
            repeat (12) begin
                r = $urandom;
                lo = r[0] ? 10'h3B0 + 10'(r[15:10]) : r[25:16];
                step(1'b1, {47'h0, r[31:30] == 2'b00, r[9:4], lo});
                // straddles the video range edges and the prefetch window ends
                step(1'b0, r[1] ? {44'h0, 4'h9 + 4'(r[3:2]), r[19:4]}
                    : {31'h0, r[2], 12'h7FF + 12'(r[11:3] % 259), r[3] ? 20'hFFFFF : 20'h0});
            end
        end
        test_done();
    end
    initial begin
        #500_000;
        fail_count++;
        test_done();
    end
endmodule : tb_top
